// [hdl/swire_pkg.sv]
// Shared constants for the single-wire trigger and response link.
package swire_pkg;
  localparam int CLK_MHZ       = 125;
  localparam int WAKE_MIN_US   = 30;
  localparam int TAIL_MIN_US   = 30;
  localparam int WAKE_MIN_CYC  = WAKE_MIN_US * CLK_MHZ;
  localparam int TAIL_MIN_CYC  = TAIL_MIN_US * CLK_MHZ;
  localparam int BIT_MIN_US    = 104;
  localparam int BIT_MAX_US    = 210;
  localparam int BIT_MIN_CYC   = BIT_MIN_US * CLK_MHZ;
  localparam int BIT_MAX_CYC   = BIT_MAX_US * CLK_MHZ;
  localparam int GAP_BASE      = 10;
  localparam int GAP_STEP      = 4;
  // Gap time divides by 1.2, that is multiplies by 5 and divides by 6.
  localparam int GAP_SCALE_NUM = 5;
  localparam int GAP_SCALE_DEN = 6;
  localparam int CNT_W         = 16;
  localparam int GAP_W         = 20;
  localparam int DATA_BITS     = 8;
  localparam int FRAME_BITS    = 10;
  localparam int RESULT_W      = 16;
  localparam int FIFO_DEPTH    = 32;
  localparam logic [1:0] MODE_SINGLE_WIRE = 2'h0;
  localparam logic [1:0] MODE_DEFAULT     = 2'h0;
  localparam logic [7:0] BYTE_GAP_DEFAULT = 8'h94;
  localparam logic       SETUP_ADDR_MODE  = 1'h0;
  localparam logic       SETUP_ADDR_GAP   = 1'h1;
endpackage

// [hdl/swire_if.sv]
// Open-drain single-wire link joining the device end and the host end.
`timescale 1ns/1ps
`default_nettype none
interface swire_if;
  logic dev_o;
  logic dev_oe;
  logic host_o;
  logic host_oe;
  logic line;

  // The pull-up holds the wire high unless an end pulls it low.
  assign line = ~((dev_oe & ~dev_o) | (host_oe & ~host_o));

  modport device (input line, output dev_o, output dev_oe);
  modport host (input line, output host_o, output host_oe);
endinterface
`default_nettype wire

// [hdl/swire_device.sv]
// Device end: trigger decode, bit time capture and two-byte response.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Bit rate kept within 4800 to 9600
// R2 - Response is two bytes, one 16-bit result
// R3 - One stop bit, no parity, idle high
// R4 - Wake at first falling edge while idle
// R5 - Host holds wake low at least 30 us
// R6 - High trigger width sets transmit bit time
// R7 - Host holds line low 30 us afterwards
// R8 - Host then releases line high
// R9 - Bit time measured anew every transaction
// R10 - Acquire and send only when triggered
// R11 - High byte, gap, then low byte
// R12 - Release line and idle after low byte
// R13 - Mode setting selects single-wire operation
// R14 - Byte gap setting governs inter-byte gap
// R15 - Setup values writable and readable back
// R16 - Host may sync triggers to interference
// R17 - Data bits sent least significant first
// R18 - Gap in us equals (10+4*setting)/1.2
// R19 - Start bit waits for host release
module swire_device
  import swire_pkg::*;
#(
  parameter int BIT_MIN = BIT_MIN_CYC,
  parameter int BIT_MAX = BIT_MAX_CYC
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  swire_if.device                  link,
  output logic                     acq_start,
  input  wire logic                acq_done,
  input  wire logic [RESULT_W-1:0] acq_result,
  input  wire logic                setup_we,
  input  wire logic                setup_addr,
  input  wire logic [7:0]          setup_wdata,
  output logic [7:0]               setup_rdata,
  output logic [1:0]               serial_mode_setting,
  output logic [7:0]               byte_gap_setting,
  output logic                     busy
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAKE = 3'h1,
    ST_BAUD = 3'h2,
    ST_TAIL = 3'h3,
    ST_ACQ  = 3'h4,
    ST_TX   = 3'h5,
    ST_GAP  = 3'h6
  } dev_state_e;

  typedef struct packed {
    logic                s1;
    logic                s2;
    logic                s3;
    dev_state_e          st;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    bit_cyc;
    logic [GAP_W-1:0]    gap;
    logic [FRAME_BITS-1:0] sh;
    logic [3:0]          nbit;
    logic                second;
    logic [RESULT_W-1:0] res;
    logic                oe;
    logic                acq_go;
    logic [1:0]          mode;
    logic [7:0]          gap_set;
    logic [7:0]          rdata;
  } dev_s;

  dev_s r;
  dev_s n;

  logic             rise;
  logic             fall;
  logic [31:0]      gap_full;
  logic [GAP_W-1:0] gap_cyc;

  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;

  // Gap in clock cycles from the stored setting.
  assign gap_full = (32'(GAP_BASE) + 32'(GAP_STEP) * 32'(r.gap_set))
                    * 32'(CLK_MHZ * GAP_SCALE_NUM) / 32'(GAP_SCALE_DEN); // see R18
  assign gap_cyc  = gap_full[GAP_W-1:0]; // see R14

  always_comb begin
    n        = r;
    n.s1     = link.line;
    n.s2     = r.s1;
    n.s3     = r.s2;
    n.acq_go = 1'b0;

    // Setup store, written and read back at any time.
    if (setup_we) begin
      if (setup_addr == SETUP_ADDR_GAP) begin
        n.gap_set = setup_wdata; // see R15
      end else begin
        n.mode = setup_wdata[1:0]; // see R15
      end
    end
    if (setup_addr == SETUP_ADDR_GAP) begin
      n.rdata = r.gap_set; // see R15
    end else begin
      n.rdata = {6'h00, r.mode};
    end

    unique case (r.st)
      ST_IDLE: begin
        // Only a host trigger leaves idle, and only in single-wire mode.
        if (r.mode == MODE_SINGLE_WIRE && fall) begin // see R4 R13 R10
          n.st  = ST_WAKE;
          n.cnt = '0;
        end
      end
      ST_WAKE: begin
        if (rise) begin
          n.st  = ST_BAUD;
          n.cnt = '0;
        end
      end
      ST_BAUD: begin
        if (r.cnt != '1) begin
          n.cnt = r.cnt + 1'b1;
        end
        if (fall) begin
          // Width out of the legal rate range aborts the transaction.
          if (32'(r.cnt) + 32'd1 >= 32'(BIT_MIN) &&
              32'(r.cnt) + 32'd1 <= 32'(BIT_MAX)) begin // see R1
            n.bit_cyc = r.cnt + 1'b1; // see R6 R9
            n.st      = ST_TAIL;
          end else begin
            n.st = ST_IDLE;
          end
        end
      end
      ST_TAIL: begin
        if (rise) begin // see R19
          n.st     = ST_ACQ;
          n.acq_go = 1'b1;
        end
      end
      ST_ACQ: begin
        if (acq_done) begin
          n.res    = acq_result; // see R2
          n.sh     = {1'b1, acq_result[RESULT_W-1:DATA_BITS], 1'b0}; // see R11
          n.nbit   = '0;
          n.cnt    = '0;
          n.second = 1'b0;
          n.st     = ST_TX;
        end
      end
      ST_TX: begin
        if (r.cnt == r.bit_cyc - 1'b1) begin
          n.cnt  = '0;
          n.sh   = {1'b1, r.sh[FRAME_BITS-1:1]}; // see R17
          n.nbit = r.nbit + 1'b1;
          if (r.nbit == 4'(FRAME_BITS - 1)) begin // see R3
            if (r.second) begin
              n.st = ST_IDLE; // see R12
            end else begin
              n.gap = gap_cyc; // see R14
              n.st  = ST_GAP;
            end
          end
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      ST_GAP: begin
        n.gap = r.gap - 1'b1;
        if (r.gap == GAP_W'(1)) begin
          n.sh     = {1'b1, r.res[DATA_BITS-1:0], 1'b0}; // see R11
          n.nbit   = '0;
          n.cnt    = '0;
          n.second = 1'b1;
          n.st     = ST_TX;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Pull low only for zero bits; a one or idle leaves the pull-up.
    n.oe = (n.st == ST_TX) & ~n.sh[0]; // see R3 R12

    if (sys_rst) begin
      n         = '0;
      n.s1      = 1'b1;
      n.s2      = 1'b1;
      n.s3      = 1'b1;
      n.st      = ST_IDLE;
      n.sh      = '1;
      n.mode    = MODE_DEFAULT;
      n.gap_set = BYTE_GAP_DEFAULT;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign link.dev_o          = 1'b0;
  assign link.dev_oe         = r.oe;
  assign acq_start           = r.acq_go;
  assign setup_rdata         = r.rdata;
  assign serial_mode_setting = r.mode;
  assign byte_gap_setting    = r.gap_set;
  assign busy                = (r.st != ST_IDLE);

endmodule // swire_device
`default_nettype wire

// [hdl/swire_host.sv]
// Host end: trigger generator, two-byte receiver and receive FIFO.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_s;

  fifo_s r;
  fifo_s n;
  logic  push;
  logic  pop;

  assign in_ready  = (r.cnt != (AW+1)'(D));
  assign out_valid = (r.cnt != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (sys_rst) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign out_data = r.mem[r.rp];
  assign level    = r.cnt;
endmodule // byte_fifo

module swire_host
  import swire_pkg::*;
#(
  parameter int BIT_MIN = BIT_MIN_CYC,
  parameter int BIT_MAX = BIT_MAX_CYC
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  swire_if.host                 link,
  input  wire logic             trig_valid,
  output logic                  trig_ready,
  input  wire logic [CNT_W-1:0] baud_cycles,
  output logic                  rx_valid,
  input  wire logic             rx_ready,
  output logic [7:0]            rx_data,
  output logic                  busy
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_WAKE = 3'h1,
    HS_BAUD = 3'h2,
    HS_TAIL = 3'h3,
    HS_WAIT = 3'h4,
    HS_HALF = 3'h5,
    HS_BITS = 3'h6
  } host_state_e;

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    host_state_e      st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] bit_cyc;
    logic [7:0]       sh;
    logic [3:0]       nbit;
    logic             second;
    logic             oe;
    logic             push;
    logic [7:0]       byte_q;
  } host_s;

  host_s r;
  host_s n;

  logic                      fall;
  logic                      f_ready;
  logic [$clog2(FIFO_DEPTH):0] f_level;

  assign fall = ~r.s2 & r.s3;
  // A new trigger needs room for both answer bytes in the FIFO.
  assign trig_ready = (r.st == HS_IDLE) & ~r.push &
                      (32'(f_level) <= FIFO_DEPTH - 2);

  always_comb begin
    n    = r;
    n.s1 = link.line;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.push & f_ready) begin
      n.push = 1'b0;
    end
    unique case (r.st)
      HS_IDLE: begin
        if (trig_valid & trig_ready) begin
          // Requested bit time is clamped into the legal rate range.
          if (32'(baud_cycles) < BIT_MIN) begin // see R1
            n.bit_cyc = CNT_W'(BIT_MIN);
          end else if (32'(baud_cycles) > BIT_MAX) begin
            n.bit_cyc = CNT_W'(BIT_MAX);
          end else begin
            n.bit_cyc = baud_cycles;
          end
          n.cnt    = '0;
          n.second = 1'b0;
          n.st     = HS_WAKE;
        end
      end
      HS_WAKE: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(WAKE_MIN_CYC - 1)) begin // see R5
          n.cnt = '0;
          n.st  = HS_BAUD;
        end
      end
      HS_BAUD: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == r.bit_cyc - 1'b1) begin // see R6
          n.cnt = '0;
          n.st  = HS_TAIL;
        end
      end
      HS_TAIL: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == CNT_W'(TAIL_MIN_CYC - 1)) begin // see R7
          n.st = HS_WAIT; // see R8
        end
      end
      HS_WAIT: begin
        if (fall) begin
          n.cnt = '0;
          n.st  = HS_HALF;
        end
      end
      HS_HALF: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == (r.bit_cyc >> 1)) begin
          n.cnt  = '0;
          n.nbit = '0;
          n.st   = r.s2 ? HS_WAIT : HS_BITS;
        end
      end
      HS_BITS: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == r.bit_cyc - 1'b1) begin
          n.cnt = '0;
          if (r.nbit != 4'(DATA_BITS)) begin
            n.sh   = {r.s2, r.sh[7:1]}; // see R17
            n.nbit = r.nbit + 1'b1;
          end else begin
            n.push   = 1'b1;
            n.byte_q = r.sh;
            n.second = 1'b1;
            n.st     = r.second ? HS_IDLE : HS_WAIT; // see R2
          end
        end
      end
      default: begin
        n.st = HS_IDLE;
      end
    endcase
    n.oe = (n.st == HS_WAKE) | (n.st == HS_TAIL);
    if (sys_rst) begin
      n    = '0;
      n.s1 = 1'b1;
      n.s2 = 1'b1;
      n.s3 = 1'b1;
      n.st = HS_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  byte_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) byte_fifo_i (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (r.push),
    .in_ready  (f_ready),
    .in_data   (r.byte_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .level     (f_level)
  );

  assign link.host_o  = 1'b0;
  assign link.host_oe = r.oe;
  assign busy         = (r.st != HS_IDLE) | r.push;

endmodule // swire_host
`default_nettype wire

// [dv/swire_link_chk.sv]
// Checker for the open-drain single-wire link between the two ends.
`timescale 1ns/1ps
`default_nettype none
module swire_link_chk
  import swire_pkg::*;
#(
  parameter int BIT_MIN = BIT_MIN_CYC,
  parameter int BIT_MAX = BIT_MAX_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic line
);
  logic [15:0] host_run_r;
  // Nine bit times at the slowest rate need more than sixteen bits.
  logic [17:0] dev_hi_r;
  logic [15:0] dev_lo_r;

  // Run lengths of each pull; the idle run saturates instead of wrapping.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_run_r <= 16'h0000;
      dev_hi_r   <= 18'h00000;
      dev_lo_r   <= 16'h0000;
    end else begin
      host_run_r <= host_oe ? host_run_r + 16'h0001 : 16'h0000;
      dev_hi_r   <= dev_oe ? dev_hi_r + 18'h00001 : 18'h00000;
      dev_lo_r   <= dev_oe ? 16'h0000 : dev_lo_r + {15'h0000, ~&dev_lo_r};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_dev_open_drain;
    dev_o == 1'b0;
  endproperty
  a_dev_open_drain: assert property (p_dev_open_drain)
    else $error("device drives the wire high");

  property p_host_open_drain;
    host_o == 1'b0;
  endproperty
  a_host_open_drain: assert property (p_host_open_drain)
    else $error("host drives the wire high");

  property p_reset_quiet;
    $fell(sys_rst) |-> !dev_oe && !host_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("wire pulled at reset release");

  property p_host_hold;
    $fell(host_oe) |-> host_run_r >= WAKE_MIN_CYC;
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host low run too short");

  property p_dev_bit_low;
    $rose(dev_oe) |-> dev_lo_r >= BIT_MIN;
  endproperty
  a_dev_bit_low: assert property (p_dev_bit_low)
    else $error("high level shorter than a bit");

  property p_dev_bit_high;
    $fell(dev_oe) |-> dev_hi_r >= BIT_MIN && dev_hi_r <= 9 * BIT_MAX;
  endproperty
  a_dev_bit_high: assert property (p_dev_bit_high)
    else $error("device low run outside frame bounds");

  property p_start_after_release;
    $rose(dev_oe) |-> $past(line) && !host_oe;
  endproperty
  a_start_after_release: assert property (p_start_after_release)
    else $error("start bit before host release");

  property p_no_contention;
    dev_oe |-> !host_oe;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends pull the wire");
endmodule // swire_link_chk
`default_nettype wire

// [dv/tb_single_wire_trigger_uart_port.sv]
// Self-checking bench joining the device end and the host end.
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_trigger_uart_port
  import swire_pkg::*;
;
  localparam int BMIN  = 20;
  localparam int BMAX  = 60;
  // The host clamps more loosely so that a width the device refuses can pass.
  localparam int BHOST = 80;
  logic                clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                acq_start;
  logic                acq_done = 1'b0;
  logic [RESULT_W-1:0] acq_result = 16'h0000;
  logic                setup_we = 1'b0;
  logic                setup_addr = 1'b0;
  logic [7:0]          setup_wdata = 8'h00;
  logic [7:0]          setup_rdata;
  logic [1:0]          serial_mode_setting;
  logic [7:0]          byte_gap_setting;
  logic                dev_busy;
  logic                trig_valid = 1'b0;
  logic                trig_ready;
  logic [CNT_W-1:0]    baud_cycles = 16'h0014;
  logic                rx_valid;
  logic                rx_ready = 1'b0;
  logic [7:0]          rx_data;
  logic                host_busy;
  int                  fail_count = 0;
  int                  n_checks = 0;

  always #4 clk = ~clk;

  swire_if swire_if_i ();
  swire_device #(.BIT_MIN(BMIN), .BIT_MAX(BMAX)) swire_device_i (
    .clk, .sys_rst, .link(swire_if_i), .acq_start, .acq_done, .acq_result,
    .setup_we, .setup_addr, .setup_wdata, .setup_rdata,
    .serial_mode_setting, .byte_gap_setting, .busy(dev_busy)
  );
  swire_host #(.BIT_MIN(BMIN), .BIT_MAX(BHOST)) swire_host_i (
    .clk, .sys_rst, .link(swire_if_i), .trig_valid, .trig_ready,
    .baud_cycles, .rx_valid, .rx_ready, .rx_data, .busy(host_busy)
  );
  swire_link_chk #(.BIT_MIN(BMIN), .BIT_MAX(BMAX)) swire_link_chk_i (
    .clk, .sys_rst, .dev_o(swire_if_i.dev_o), .dev_oe(swire_if_i.dev_oe),
    .host_o(swire_if_i.host_o), .host_oe(swire_if_i.host_oe),
    .line(swire_if_i.line)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
    end
  endtask

  // Inputs always change one nanosecond after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return swire_if_i.line;
      default: return acq_start;
    endcase
  endfunction

  task automatic wait_lvl(input int k, input logic v, output int n);
    n = 0;
    while (sig(k) !== v) begin
      tick(1);
      n++;
      if (n > 20000) begin
        check(0, 1, "timeout");
        test_done();
      end
    end
  endtask

  task automatic setup_wr(input logic a, input logic [7:0] d);
    setup_addr = a;
    setup_wdata = d;
    setup_we = 1'b1;
    tick(1);
    setup_we = 1'b0;
    tick(1);
    check(setup_rdata, d, "setup readback");
  endtask

  task automatic t_defaults();
    check(serial_mode_setting, MODE_DEFAULT, "mode default");
    check(byte_gap_setting, BYTE_GAP_DEFAULT, "gap default");
    check(swire_if_i.line, 1'b1, "idle level");
    check({dev_busy, acq_start}, 2'h0, "device quiet");
  endtask

  task automatic t_xfer(input int b, input logic [15:0] res, input int g);
    int n;
    setup_wr(SETUP_ADDR_GAP, g[7:0]);
    check(byte_gap_setting, g, "gap setting");
    check(trig_ready, 1'b1, "host ready");
    baud_cycles = CNT_W'(b);
    trig_valid = 1'b1;
    tick(1);
    trig_valid = 1'b0;
    wait_lvl(1, 1'b1, n);
    tick(4);
    acq_result = res;
    acq_done = 1'b1;
    tick(1);
    acq_done = 1'b0;
    wait_lvl(0, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    check(n, b, "start bit width");
    tick(7 * b);
    wait_lvl(0, 1'b0, n);
    check(n, 2 * b + (10 + 4 * g) * 625 / 6, "byte gap");
    wait_lvl(0, 1'b1, n);
    check(n, b, "second start width");
    tick(10 * b);
    check(swire_if_i.line, 1'b1, "line released");
    check(dev_busy, 1'b0, "device idle");
    check(rx_valid, 1'b1, "bytes held");
    check(host_busy, 1'b0, "host idle");
  endtask

  task automatic t_drain();
    logic [7:0] exp [4] = '{8'hA5, 8'hC3, 8'h81, 8'h7F};
    rx_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      check(rx_valid, 1'b1, "fifo valid");
      check(rx_data, exp[i], "byte value");
      tick(1);
    end
    rx_ready = 1'b0;
    check(rx_valid, 1'b0, "fifo empty");
  endtask

  task automatic t_mode_off();
    logic seen;
    seen = 1'b0;
    setup_wr(SETUP_ADDR_MODE, 8'h02);
    check(serial_mode_setting, 2'h2, "mode setting");
    trig_valid = 1'b1;
    tick(1);
    trig_valid = 1'b0;
    repeat (9000) begin
      tick(1);
      seen = seen | acq_start | swire_if_i.dev_oe;
    end
    check(seen, 1'b0, "trigger ignored");
  endtask

  task automatic t_reset();
    sys_rst = 1'b1;
    tick(8);
    sys_rst = 1'b0;
    tick(3);
    t_defaults();
    check({host_busy, trig_ready}, 2'h1, "host idle after reset");
  endtask

  task automatic t_reject();
    logic seen;
    seen = 1'b0;
    check(trig_ready, 1'b1, "host ready");
    baud_cycles = CNT_W'(BMAX + 10);
    trig_valid = 1'b1;
    tick(1);
    trig_valid = 1'b0;
    repeat (9000) begin
      tick(1);
      seen = seen | acq_start | swire_if_i.dev_oe;
    end
    check(seen, 1'b0, "width out of range ignored");
    check(dev_busy, 1'b0, "device back to idle");
  endtask

  initial begin
    tick(8);
    sys_rst = 1'b0;
    tick(3);
    t_defaults();
    t_xfer(BMIN, 16'hA5C3, 0);
    t_xfer(BMAX, 16'h817F, 1);
    t_drain();
    t_mode_off();
    t_reset();
    t_reject();
    test_done();
  end
endmodule // tb_single_wire_trigger_uart_port
`default_nettype wire
